// >>> verilog/ccd_pkg.sv
/*
  Package of the configuration command decoder: command codes, register
  offsets, control register 0 layout and the over-temperature timing.
  Assumes a single 50 MHz clock and a plain strobe register port.
*/

package ccd_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CCD_NOP        = 5'h00,
    CCD_CLR_CRC    = 5'h01,
    CCD_SWITCH     = 5'h02,
    CCD_WR_OPEN    = 5'h04,
    CCD_REPLICATE  = 5'h05,
    CCD_RD_OPEN    = 5'h06,
    CCD_WAKE_START = 5'h07,
    CCD_WAKE_STOP  = 5'h08,
    CCD_LOGIC_ON   = 5'h09,
    CCD_LOGIC_OFF  = 5'h0a,
    CCD_UNLOCK     = 5'h0b,
    CCD_WDOG       = 5'h0c,
    CCD_RB_CLR     = 5'h0d,
    CCD_RB_CHECK   = 5'h0e,
    CCD_WARMBOOT   = 5'h0f,
    CCD_WR_CLOSE   = 5'h10,
    CCD_RD_CLOSE   = 5'h11
  } ccd_cmd_t;

  // ----------------------------------------------------------------
  // register offsets (5-bit packet addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] CCD_ADR_COMMAND = 5'h02;
  localparam logic [4:0] CCD_ADR_CTRL0 = 5'h03;
  localparam logic [4:0] CCD_ADR_REPEAT = 5'h06;
  localparam logic [4:0] CCD_ADR_STATUS = 5'h14;
  localparam logic [4:0] CCD_ADR_IRQ = 5'h15;
  localparam logic [4:0] CCD_ADR_MASK = 5'h16;

  // ----------------------------------------------------------------
  // control register 0 fields and reset values
  // ----------------------------------------------------------------
  localparam int CCD_OTSD_BIT = 22;
  localparam int CCD_FSEL_LSB = 16;
  localparam int CCD_FSEL_W = 6;
  localparam logic [31:0] CCD_CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] CCD_CTRL0_WMASK = 32'h007f_ffff;
  localparam logic [31:0] CCD_REPEAT_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // interrupt bits
  // ----------------------------------------------------------------
  localparam int CCD_IRQ_W = 4;
  localparam int CCD_IRQ_CMD = 0;
  localparam int CCD_IRQ_OT = 1;
  localparam int CCD_IRQ_DOWN = 2;
  localparam int CCD_IRQ_UP = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  // the count is fixed in cycles: 10 ms only when the config clock runs at 50 MHz
  localparam int CCD_OT_REF_HZ = 50_000_000;
  localparam int CCD_OT_DELAY_MS = 10;
  localparam int CCD_OT_CYCLES = (CCD_OT_REF_HZ / 1000) * CCD_OT_DELAY_MS;
  localparam int CCD_GLOBAL_STEPS = 4;

endpackage

// >>> verilog/ccd_decoder.sv
/*
  Configuration command decoder with over-temperature shutdown sequencer.
  Assumes the packet parser presents register writes and reads over the
  strobe port, and that over_temp_i is synchronous to ref_clk_i, which is
  the internal configuration clock.
*/
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module ccd_decoder #(
  parameter int OT_CYCLES = ccd_pkg::CCD_OT_CYCLES,
  parameter int GLOBAL_STEPS = ccd_pkg::CCD_GLOBAL_STEPS
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic fallback_active_i,
  input wire logic over_temp_i,
  output logic crc_clear_o,
  output logic clk_switch_o,
  output logic [5:0] clk_fsel_o,
  output logic replicate_o,
  output logic [31:0] replicate_count_o,
  output logic watchdog_restart_o,
  output logic readback_clear_o,
  output logic readback_check_o,
  output logic warmboot_o,
  output logic frame_write_en_o,
  output logic frame_read_en_o,
  output logic wake_run_o,
  output logic logic_on_o,
  output logic synced_o,
  input wire logic resync_i,
  output logic [GLOBAL_STEPS-1:0] global_on_o,
  output logic logic_enable_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  // codes 5 to 7 are never reached; the default returns them to run
  typedef enum logic [2:0] {
    CCD_S_RUN = 3'b000,
    CCD_S_COUNT = 3'b001,
    CCD_S_DOWN = 3'b010,
    CCD_S_OFF = 3'b011,
    CCD_S_UP = 3'b100
  } ccd_state_t;

  localparam int CW = $clog2(OT_CYCLES + 1);
  localparam int CCD_IRQ_W_L = ccd_pkg::CCD_IRQ_W;

  // ----------------------------------------------------------------
  // internal signals
  // ----------------------------------------------------------------
  logic [31:0] ctrl0;
  logic [31:0] repeat_cnt;
  logic [CCD_IRQ_W_L-1:0] irq_stat;
  logic [CCD_IRQ_W_L-1:0] irq_mask;
  logic [CCD_IRQ_W_L-1:0] irq_set;
  logic cmd_wr;
  logic [4:0] cmd;
  logic ot_prev;
  logic ot_rise;
  logic ot_start;
  logic [CW-1:0] ot_cnt;
  ccd_state_t state;
  ccd_state_t next_state;
  logic down_done;
  logic up_done;

  // the parser hands one word per strobe, so a write carries one code
  // command strobe only counts while packets are interpreted
  assign cmd_wr = wr_i && (addr_i == ccd_pkg::CCD_ADR_COMMAND) && synced_o;
  assign cmd = wdata_i[4:0]; // one code per write

  // ----------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------
  // control register 0: reserved top bits never stored, so they read as zero
  // the frequency field acts only when the clock switch command arrives
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl0 <= ccd_pkg::CCD_CTRL0_RST;
    else if (wr_i && addr_i == ccd_pkg::CCD_ADR_CTRL0)
      ctrl0 <= wdata_i & ccd_pkg::CCD_CTRL0_WMASK;
  end

  // frame repeat count register
  // sampled by the frame logic when the replicate pulse fires
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      repeat_cnt <= ccd_pkg::CCD_REPEAT_RST;
    else if (wr_i && addr_i == ccd_pkg::CCD_ADR_REPEAT)
      repeat_cnt <= wdata_i;
  end

  // interrupt mask
  // a set mask bit lets the matching status bit reach irq_o
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_mask <= '0;
    else if (wr_i && addr_i == ccd_pkg::CCD_ADR_MASK)
      irq_mask <= wdata_i[CCD_IRQ_W_L-1:0];
  end

  assign clk_fsel_o = ctrl0[ccd_pkg::CCD_FSEL_LSB +: ccd_pkg::CCD_FSEL_W];
  assign replicate_count_o = repeat_cnt;

  // ----------------------------------------------------------------
  // one-cycle command pulses
  // ----------------------------------------------------------------
  // pulses last exactly one cycle after the write; unknown codes give none
  // registered so consumers see clean single-cycle strobes
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      crc_clear_o <= 1'b0;
      clk_switch_o <= 1'b0;
      replicate_o <= 1'b0;
      watchdog_restart_o <= 1'b0;
      readback_clear_o <= 1'b0;
      readback_check_o <= 1'b0;
      warmboot_o <= 1'b0;
    end
    else
    begin
      crc_clear_o <= cmd_wr && cmd == ccd_pkg::CCD_CLR_CRC;
      clk_switch_o <= cmd_wr && cmd == ccd_pkg::CCD_SWITCH;
      replicate_o <= cmd_wr && cmd == ccd_pkg::CCD_REPLICATE;
      watchdog_restart_o <= cmd_wr && cmd == ccd_pkg::CCD_WDOG;
      readback_clear_o <= cmd_wr && cmd == ccd_pkg::CCD_RB_CLR;
      readback_check_o <= cmd_wr && cmd == ccd_pkg::CCD_RB_CHECK;
      // fallback is sampled in the write cycle itself
      warmboot_o <= cmd_wr && cmd == ccd_pkg::CCD_WARMBOOT
                    && !fallback_active_i;
    end
  end

  // ----------------------------------------------------------------
  // level state set and cleared by commands, except sync, which the parser regains
  // ----------------------------------------------------------------
  // frame access gates; other codes leave them alone
  // open and close never coincide, since each write carries one code
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frame_write_en_o <= 1'b0;
      frame_read_en_o <= 1'b0;
    end
    else if (cmd_wr)
    begin
      if (cmd == ccd_pkg::CCD_WR_OPEN)
        frame_write_en_o <= 1'b1;
      else if (cmd == ccd_pkg::CCD_WR_CLOSE)
        frame_write_en_o <= 1'b0;
      if (cmd == ccd_pkg::CCD_RD_OPEN)
        frame_read_en_o <= 1'b1;
      else if (cmd == ccd_pkg::CCD_RD_CLOSE)
        frame_read_en_o <= 1'b0;
    end
  end

  // wakeup run flag and internal logic switch
  // both stay as they are through an over-temperature shutdown
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wake_run_o <= 1'b0;
      logic_on_o <= 1'b0;
    end
    else if (cmd_wr)
    begin
      if (cmd == ccd_pkg::CCD_WAKE_START)
        wake_run_o <= 1'b1;
      else if (cmd == ccd_pkg::CCD_WAKE_STOP)
        wake_run_o <= 1'b0;
      if (cmd == ccd_pkg::CCD_LOGIC_ON)
        logic_on_o <= 1'b1;
      else if (cmd == ccd_pkg::CCD_LOGIC_OFF)
        logic_on_o <= 1'b0;
    end
  end

  // sync state: dropped by the unlock command, regained by the parser
  // unlock is tested first, so a resync in the same cycle cannot undo it
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      synced_o <= 1'b1;
    else if (cmd_wr && cmd == ccd_pkg::CCD_UNLOCK)
      synced_o <= 1'b0;
    else if (resync_i)
      synced_o <= 1'b1;
  end

  // ----------------------------------------------------------------
  // over-temperature sequencer
  // ----------------------------------------------------------------
  // ref_clk_i is the configuration clock, so no crossing is needed
  // reset value equals the idle level of over_temp_i, so no false edge follows reset
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ot_prev <= 1'b0;
    else
      ot_prev <= over_temp_i;
  end

  assign ot_rise = over_temp_i && !ot_prev;
  assign ot_start = ot_rise && ctrl0[ccd_pkg::CCD_OTSD_BIT];
  assign down_done = global_on_o == '0;
  assign up_done = &global_on_o;

  // the host must finish configuration traffic before the count ends
  // the count is fixed in cycles, so its duration scales with the clock rate
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ot_cnt <= '0;
    else if (state == CCD_S_RUN && ot_start)
      ot_cnt <= CW'(OT_CYCLES - 1);
    else if (state == CCD_S_COUNT && ot_cnt != '0)
      ot_cnt <= ot_cnt - 1'b1;
  end

  // a cooled die during the count simply resumes; nothing was switched off
  always_comb
  begin
    next_state = state;
    unique case (state)
      CCD_S_RUN:
        if (ot_start)
          next_state = CCD_S_COUNT;
      CCD_S_COUNT:
        if (!over_temp_i)
          next_state = CCD_S_RUN;
        else if (ot_cnt == '0)
          next_state = CCD_S_DOWN;
      CCD_S_DOWN:
        if (down_done)
          next_state = CCD_S_OFF;
      CCD_S_OFF:
        if (!over_temp_i)
          next_state = CCD_S_UP;
      CCD_S_UP:
        if (up_done)
          next_state = CCD_S_RUN;
      default:
        next_state = CCD_S_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      state <= CCD_S_RUN;
    else
      state <= next_state;
  end

  // global signals drop one per cycle from the top, rise from the bottom
  // GLOBAL_STEPS below two would leave the wake slice empty
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      global_on_o <= '1;
    else if (state == CCD_S_DOWN)
      global_on_o <= global_on_o >> 1;
    else if (state == CCD_S_UP && logic_enable_o)
      global_on_o <= {global_on_o[GLOBAL_STEPS-2:0], 1'b1};
  end

  // enable falls only after all globals are off, rises before any wakes
  // it stays high through the count, while the host may still be working
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      logic_enable_o <= 1'b1;
    else if (state == CCD_S_DOWN && down_done)
      logic_enable_o <= 1'b0;
    else if (state == CCD_S_OFF && !over_temp_i)
      logic_enable_o <= 1'b1;
  end

  // ----------------------------------------------------------------
  // interrupts and read port
  // ----------------------------------------------------------------
  // each event lasts one cycle, so it sets its bit exactly once
  always_comb
  begin
    irq_set = '0;
    irq_set[ccd_pkg::CCD_IRQ_CMD] = cmd_wr;
    irq_set[ccd_pkg::CCD_IRQ_OT] = state == CCD_S_RUN && ot_start;
    irq_set[ccd_pkg::CCD_IRQ_DOWN] = state == CCD_S_DOWN && down_done;
    irq_set[ccd_pkg::CCD_IRQ_UP] = state == CCD_S_UP && up_done;
  end

  // a read clears the status, but an event in the same cycle survives
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_stat <= '0;
    else if (rd_i && addr_i == ccd_pkg::CCD_ADR_IRQ)
      irq_stat <= irq_set;
    else
      irq_stat <= irq_stat | irq_set;
  end

  assign irq_o = |(irq_stat & irq_mask);

  // read data stands one cycle after the strobe; unmapped reads give zero
  // zero outside the answer cycle keeps stale values off the bus
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= '0;
    else if (rd_i)
    begin
      unique case (addr_i)
        ccd_pkg::CCD_ADR_CTRL0: rdata_o <= ctrl0;
        ccd_pkg::CCD_ADR_REPEAT: rdata_o <= repeat_cnt;
        ccd_pkg::CCD_ADR_STATUS: rdata_o <= {24'h0, state, synced_o, frame_read_en_o,
                                             frame_write_en_o, logic_enable_o, logic_on_o};
        ccd_pkg::CCD_ADR_IRQ: rdata_o <= {28'h0, irq_stat};
        ccd_pkg::CCD_ADR_MASK: rdata_o <= {28'h0, irq_mask};
        default: rdata_o <= '0;
      endcase
    end
    else
      rdata_o <= '0;
  end

endmodule

`default_nettype wire

// >>> tb/ccd_decoder_checker.sv
/*
  Port checker of the command decoder.
  Assumes it is bound to every ccd_decoder instance.
*/
`timescale 1ns/10ps
`default_nettype none
module ccd_decoder_checker #(
  parameter int OT_CYCLES = ccd_pkg::CCD_OT_CYCLES,
  parameter int GLOBAL_STEPS = ccd_pkg::CCD_GLOBAL_STEPS
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic fallback_active_i,
  input wire logic synced_o,
  input wire logic crc_clear_o,
  input wire logic clk_switch_o,
  input wire logic warmboot_o,
  input wire logic frame_write_en_o,
  input wire logic frame_read_en_o,
  input wire logic wake_run_o,
  input wire logic logic_on_o,
  input wire logic [GLOBAL_STEPS-1:0] global_on_o,
  input wire logic logic_enable_o
);
  // ------
  // taken command write; a desynced decoder takes none
  // ------
  logic take;
  logic [4:0] c;
  assign take = wr_i && addr_i == ccd_pkg::CCD_ADR_COMMAND && synced_o;
  assign c = wdata_i[4:0];
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  clr_pulse_a: assert property (take && c == 5'h01 |=> crc_clear_o)
    else $error("checksum clear missing");
  clk_switch_a: assert property (take && c == 5'h02 |=> clk_switch_o)
    else $error("clock switch missing");
  wr_open_a: assert property (take && c == 5'h04 |=> frame_write_en_o)
    else $error("frame write not opened");
  rd_open_a: assert property (take && c == 5'h06 |=> frame_read_en_o)
    else $error("frame read not opened");
  wake_on_a: assert property (take && c == 5'h07 |=> wake_run_o)
    else $error("wakeup not started");
  wake_off_a: assert property (take && c == 5'h08 |=> !wake_run_o)
    else $error("wakeup not stopped");
  unlock_a: assert property (take && c == 5'h0b |=> !synced_o)
    else $error("unlock_sync_cmd not taken");
  warm_block_a: assert property (take && c == 5'h0f && fallback_active_i |=> !warmboot_o)
    else $error("warmboot during fallback");
  warm_go_a: assert property (take && c == 5'h0f && !fallback_active_i |=> warmboot_o)
    else $error("warmboot not issued");
  wr_close_a: assert property (take && c == 5'h10 |=> !frame_write_en_o)
    else $error("frame write not closed");
  rd_close_a: assert property (take && c == 5'h11 |=> !frame_read_en_o)
    else $error("frame read not closed");
  down_order_a: assert property ($fell(logic_enable_o) |-> global_on_o == '0)
    else $error("enable dropped before globals");
  up_order_a: assert property ($rose(|global_on_o) |-> logic_enable_o)
    else $error("globals woke before enable");
  unknown_code_a: assert property (take && (c == 5'h03 || c > 5'h11) |=>
    $stable({frame_write_en_o, frame_read_en_o, wake_run_o, logic_on_o}))
    else $error("unknown code changed state");
  cover property (take && c == 5'h04);
  cover property ($fell(logic_enable_o));
  cover property ($rose(logic_enable_o));
endmodule
bind ccd_decoder ccd_decoder_checker #(.OT_CYCLES(OT_CYCLES), .GLOBAL_STEPS(GLOBAL_STEPS)) u_chk (
  .ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .fallback_active_i, .synced_o, .crc_clear_o,
  .clk_switch_o, .warmboot_o, .frame_write_en_o, .frame_read_en_o, .wake_run_o, .logic_on_o,
  .global_on_o, .logic_enable_o
);
`default_nettype wire

// >>> tb/ccd_host.sv
/*
  Configuration host model: drives the register strobe port.
  Assumes the bench calls its tasks and feeds back the read data.
*/
`timescale 1ns/10ps
`default_nettype none
module ccd_host (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  output logic [4:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // idle bus at time zero
  initial
  begin
    addr_o = 5'h00;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one word per strobe, so one command per write
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d; // stale data must not look valid
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench of the command decoder.
  Assumes the host model drives the register port; the bench drives the rest.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int OTC = 20;
  localparam int GS = 4;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fallback_active_i, over_temp_i, resync_i, wr_i, rd_i;
  logic [4:0] addr_i;
  logic [31:0] wdata_i, rdata_o, replicate_count_o, rv, rv2;
  logic crc_clear_o, clk_switch_o, replicate_o, watchdog_restart_o, readback_clear_o;
  logic readback_check_o, warmboot_o, frame_write_en_o, frame_read_en_o, wake_run_o;
  logic logic_on_o, synced_o, logic_enable_o, irq_o;
  logic [5:0] clk_fsel_o;
  logic [GS-1:0] global_on_o;
  logic [3:0] exp_l;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 85082;
  int n;
  wire logic [3:0] lv = {frame_write_en_o, frame_read_en_o, wake_run_o, logic_on_o};
  wire logic [6:0] pv = {crc_clear_o, clk_switch_o, replicate_o, watchdog_restart_o,
    readback_clear_o, readback_check_o, warmboot_o};
  always #20 ref_clk_i = ~ref_clk_i;
  ccd_host u_host (.clk_i(ref_clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i));
  ccd_decoder #(.OT_CYCLES(OTC), .GLOBAL_STEPS(GS)) u_dut (.ref_clk_i, .rst_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .fallback_active_i, .over_temp_i, .crc_clear_o,
    .clk_switch_o, .clk_fsel_o, .replicate_o, .replicate_count_o, .watchdog_restart_o,
    .readback_clear_o, .readback_check_o, .warmboot_o, .frame_write_en_o, .frame_read_en_o,
    .wake_run_o, .logic_on_o, .synced_o, .resync_i, .global_on_o, .logic_enable_o, .irq_o);
  // ------
  // expectations and checks
  // ------
  function automatic logic [6:0] exp_pulse(input logic [4:0] c, input logic fb);
    case (c)
      5'h01: return 7'h40;
      5'h02: return 7'h20;
      5'h05: return 7'h10;
      5'h0c: return 7'h08;
      5'h0d: return 7'h04;
      5'h0e: return 7'h02;
      5'h0f: return {6'h00, !fb};
      default: return 7'h00;
    endcase
  endfunction
  function automatic logic [3:0] next_lv(input logic [3:0] v, input logic [4:0] c);
    case (c)
      5'h04: v[3] = 1'b1;
      5'h10: v[3] = 1'b0;
      5'h06: v[2] = 1'b1;
      5'h11: v[2] = 1'b0;
      5'h07: v[1] = 1'b1;
      5'h08: v[1] = 1'b0;
      5'h09: v[0] = 1'b1;
      5'h0a: v[0] = 1'b0;
      default: ;
    endcase
    return v;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one command with random upper bits and random fallback level
  task automatic cmd(input logic [4:0] c);
    rv = $random(seed);
    fallback_active_i <= rv[31];
    u_host.wr_reg(ccd_pkg::CCD_ADR_COMMAND, {rv[26:0], c});
    exp_l = next_lv(exp_l, c);
    chk("pulses", pv, exp_pulse(c, fallback_active_i));
    chk("levels", lv, exp_l);
  endtask
  // main sequence
  initial
  begin
    fallback_active_i = 1'b0;
    over_temp_i = 1'b0;
    resync_i = 1'b0;
    exp_l = 4'h0;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    u_host.rd_reg(ccd_pkg::CCD_ADR_CTRL0, rv);
    chk("ctrl0_rst", rv, ccd_pkg::CCD_CTRL0_RST);
    rv2 = $random(seed);
    u_host.wr_reg(ccd_pkg::CCD_ADR_CTRL0, rv2);
    u_host.rd_reg(ccd_pkg::CCD_ADR_CTRL0, rv);
    chk("ctrl0", rv, rv2 & ccd_pkg::CCD_CTRL0_WMASK);
    chk("fsel", clk_fsel_o, rv2[21:16]);
    u_host.wr_reg(ccd_pkg::CCD_ADR_REPEAT, rv2);
    chk("repeat", replicate_count_o, rv2);
    u_host.rd_reg(ccd_pkg::CCD_ADR_REPEAT, rv);
    chk("repeat_rd", rv, rv2);
    for (int i = 0; i < 32; i++)
      if (i != 11)
        cmd(i[4:0]);
    repeat (60)
    begin
      rv2 = $random(seed);
      cmd(rv2[4:0] == 5'h0b ? 5'h04 : rv2[4:0]);
    end
    // hand-written warmboot corners: blocked, then taken
    fallback_active_i <= 1'b1;
    u_host.wr_reg(ccd_pkg::CCD_ADR_COMMAND, 32'h0f);
    chk("warm_fb", warmboot_o, 1'b0);
    fallback_active_i <= 1'b0;
    u_host.wr_reg(ccd_pkg::CCD_ADR_COMMAND, 32'h0f);
    chk("warm_go", warmboot_o, 1'b1);
    // unlock_sync_cmd drops later commands until resync
    cmd(5'h0b);
    chk("synced", synced_o, 1'b0);
    u_host.wr_reg(ccd_pkg::CCD_ADR_COMMAND, exp_l[3] ? 32'h10 : 32'h04);
    chk("ignored", lv, exp_l);
    @(posedge ref_clk_i) resync_i <= 1'b1;
    @(posedge ref_clk_i) resync_i <= 1'b0;
    #1 chk("resynced", synced_o, 1'b1);
    u_host.rd_reg(ccd_pkg::CCD_ADR_STATUS, rv);
    chk("status", rv, {27'h0, 1'b1, exp_l[2], exp_l[3], 1'b1, exp_l[0]});
    // interrupt masked, unmasked, cleared by read; unmapped read
    u_host.wr_reg(ccd_pkg::CCD_ADR_MASK, 32'h0);
    cmd(5'h00);
    chk("irq_masked", irq_o, 1'b0);
    u_host.wr_reg(ccd_pkg::CCD_ADR_MASK, 32'h1);
    chk("irq_on", irq_o, 1'b1);
    u_host.rd_reg(ccd_pkg::CCD_ADR_MASK, rv);
    chk("mask_rd", rv, 32'h1);
    u_host.rd_reg(ccd_pkg::CCD_ADR_IRQ, rv);
    chk("irq_bit", rv[0], 1'b1);
    chk("irq_clr", irq_o, 1'b0);
    u_host.rd_reg(5'h1f, rv);
    chk("unmapped", rv, 32'h0);
    // over-temperature with shutdown disabled does nothing
    u_host.wr_reg(ccd_pkg::CCD_ADR_CTRL0, 32'h0);
    @(posedge ref_clk_i) over_temp_i <= 1'b1;
    repeat (OTC + 20) @(posedge ref_clk_i);
    #1 chk("ot_off", logic_enable_o, 1'b1);
    @(posedge ref_clk_i) over_temp_i <= 1'b0;
    // enabled: count, globals down, then enable low; recover in reverse
    u_host.wr_reg(ccd_pkg::CCD_ADR_CTRL0, 32'h0040_0000);
    // a short overheat that cools during the count switches nothing off
    @(posedge ref_clk_i) over_temp_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    over_temp_i <= 1'b0;
    repeat (OTC + 10) @(posedge ref_clk_i);
    #1 chk("ot_abort", {logic_enable_o, global_on_o}, {1'b1, {GS{1'b1}}});
    @(posedge ref_clk_i) over_temp_i <= 1'b1;
    // host traffic runs beside the count and ends well before expiry
    fork
      cmd(5'h09);
    join_none
    n = 0;
    while (logic_enable_o !== 1'b0 && n < 200)
    begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    chk("ot_min", n >= OTC, 1'b1);
    chk("ot_max", n <= OTC + GS + 3, 1'b1);
    chk("ot_down", global_on_o, '0);
    @(posedge ref_clk_i) over_temp_i <= 1'b0;
    n = 0;
    while (global_on_o !== '1 && n < 50)
    begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    chk("wake_en", logic_enable_o, 1'b1);
    chk("wake_time", n <= GS + 3, 1'b1);
    end_sim();
  end
  // watchdog: a hang ends the run as a failure
  initial
  begin
    #(40 * 20000);
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
